// *** common/rwc_pkg.sv ***
// Package for the reset and watchdog control block: bus carriers, fuse set,
// register map, field positions and timing constants.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package rwc_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CLK_HZ          = 100_000_000;
  // Watchdog oscillator rate, emulated by a divider of the system clock.
  localparam int unsigned WDT_OSC_HZ      = 128_000;
  // Divider rounds down, so the emulated oscillator runs slightly fast.
  localparam int unsigned WDT_OSC_DIV     = CLK_HZ / WDT_OSC_HZ;
  // Shortest period in oscillator ticks; each select step doubles it.
  localparam int unsigned WDT_BASE_TICKS  = 2048;
  // Highest legal select code, the longest period.
  localparam logic [3:0]  WDT_SEL_MAX     = 4'h9;
  // Least time a supply drop must last before it counts, in ns.
  localparam int unsigned BROWNOUT_MIN_NS = 2000;
  localparam int unsigned BROWNOUT_MIN_CYC =
    (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] BROWNOUT_LAST   = 16'(BROWNOUT_MIN_CYC - 1);
  // Cycles for which the change enable stays open.
  localparam logic [2:0]  CHANGE_WINDOW   = 3'h4;
  // Start-up delay unit in cycles, shifted by the fuse settings.
  localparam int unsigned STARTUP_UNIT_CYC = 64;
  // Brown-out level code that means the detector is disabled.
  localparam logic [2:0]  BROWNOUT_OFF    = 3'h7;

  // Register byte offsets.
  localparam logic [7:0]  REG_RST_FLAGS   = 8'h00;
  localparam logic [7:0]  REG_WDT_CTRL    = 8'h04;
  localparam logic [7:0]  REG_REF_CTRL    = 8'h08;

  // Reset flag positions.
  localparam int unsigned FLG_POWERON     = 0;
  localparam int unsigned FLG_EXTERNAL    = 1;
  localparam int unsigned FLG_BROWNOUT    = 2;
  localparam int unsigned FLG_WATCHDOG    = 3;
  // Watchdog control positions.
  localparam int unsigned WC_SEL0         = 0;
  localparam int unsigned WC_SEL2         = 2;
  localparam int unsigned WC_SYSRST       = 3;
  localparam int unsigned WC_CHANGE       = 4;
  localparam int unsigned WC_SEL3         = 5;
  localparam int unsigned WC_IRQ_EN       = 6;
  localparam int unsigned WC_IRQ_FLAG     = 7;
  // Reference control position.
  localparam int unsigned RC_CMP_BANDGAP  = 0;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // Master to slave signals of the register bus.
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } rwc_axi_req_t;

  // Slave to master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } rwc_axi_rsp_t;

  // Fuse settings; a one means programmed.
  typedef struct packed {
    logic       always_on_fuse;
    logic       ext_reset_disable_fuse;
    logic [2:0] brownout_level_fuses;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_select_fuses;
  } rwc_fuse_t;

endpackage

// *** design/rwc_ctrl.sv ***
// Reset combiner, start-up delay, brown-out filter, watchdog and bandgap
// enable, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to aclk and fuses are static.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Any reset returns control registers but not flags; CPU restarts at vector.
// RL2: Port reset follows sources asynchronously, clock-free.
// RL3: Release delayed by fuse-selected startup count.
// RL4: Power-on, pin, watchdog, brown-out all reset.
// RL5: Low pin resets without clock; short pulses unspecified.
// RL6: Disable fuse makes the reset pin ignored.
// RL7: Watchdog expiry resets only in reset or combined mode.
// RL8: Brown-out resets at once, releases via delay.
// RL9: Brief supply dips are filtered out.
// RL10: Power-on reset asserts immediately, releases via delay.
// RL11: Watchdog reset is one cycle; delay follows.
// RL12: Bandgap on for brown-out, comparator or converter.
// RL13: Watchdog counts oscillator ticks to selected limit.
// RL14: Restart instruction clears the watchdog counter.
// RL15: Interrupt mode raises wake-capable request at expiry.
// RL16: Combined mode interrupts first, then resets.
// RL17: Always-on fuse forces reset mode, interrupt off.
// RL18: Software opens change with change and reset bits.
// RL19: Change accepted from one write within four cycles.
// RL20: Periods span shortest to longest selection.
// RL21: Change enable clears itself after four cycles.
// RL22: Watchdog flag forces reset enable set.
// RL23: Per-source flags; power-on clears others; write-zero clears.
// RL24: Vector taken in combined mode clears enable, flag.
// RL25: Sources ORed; reassertion restarts the delay.
module rwc_ctrl #(
  parameter int unsigned OSC_DIV      = rwc_pkg::WDT_OSC_DIV,      // Watchdog tick divider.
  parameter int unsigned STARTUP_UNIT = rwc_pkg::STARTUP_UNIT_CYC  // Start-up delay unit.
) (
  input  wire logic                  aclk,              // System clock.
  input  wire logic                  aresetn,           // Synchronous reset, low.
  input  wire rwc_pkg::rwc_axi_req_t axi_req,           // Bus master signals.
  output rwc_pkg::rwc_axi_rsp_t      axi_rsp,           // Bus slave signals.
  input  wire rwc_pkg::rwc_fuse_t    fuses,             // Static fuse set.
  input  wire logic                  supply_ok,         // Low while below power-on level.
  input  wire logic                  ext_reset_pin_n,   // External reset pin, low active.
  input  wire logic                  brownout_below,    // Detector reports supply low.
  input  wire logic                  adc_enable,        // Converter is enabled.
  input  wire logic                  wdt_restart,       // Restart instruction executed.
  input  wire logic                  wdt_vector_taken,  // Watchdog vector executed.
  output logic                       cpu_reset_n,       // Internal reset, low active.
  output logic                       io_port_reset,     // Asynchronous port reset.
  output logic                       wdt_irq,           // Watchdog interrupt request.
  output logic                       bandgap_en         // Bandgap reference enable.
);
  import rwc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic        aw_hold_q, w_hold_q;     // Captured write address and data.
  logic [7:0]  awaddr_q;                // Held write address.
  logic [31:0] wdata_q;                 // Held write data.
  logic [3:0]  wstrb_q;                 // Held write strobes.
  logic        bvalid_q, rvalid_q;      // Pending responses.
  logic [1:0]  bresp_q, rresp_q;        // Response codes.
  logic [31:0] rdata_q;                 // Read data.
  logic        wr_fire;                 // A write is performed this cycle.
  logic        wdt_wr, flags_wr, ref_wr;// Write decodes.
  logic [7:0]  wbyte;                   // Low byte of the write.
  logic [3:0]  rst_flags_q;             // Reset cause flags.
  logic        cmp_bg_q;                // Comparator bandgap select.
  logic        irq_flag_q, irq_en_q;    // Watchdog interrupt flag and enable.
  logic        sysrst_q, change_en_q;   // Reset enable and change enable.
  logic [2:0]  change_cnt_q;            // Change window counter.
  logic [3:0]  sel_q;                   // Time-out selection.
  logic        sysrst_eff, irq_en_eff;  // Effective mode bits.
  logic [31:0] div_q;                   // Oscillator tick divider.
  logic [19:0] wdt_cnt_q;               // Watchdog tick counter.
  logic        tick, expire, wdt_run;   // Watchdog timing events.
  logic        wdt_pulse_q;             // One-cycle watchdog reset.
  logic [15:0] filt_q;                  // Brown-out duration counter.
  logic        brownout_active_q;       // Filtered brown-out reset.
  logic        brownout_enabled;        // Detector enabled by fuses.
  logic        por_active, ext_active;  // Raw reset sources.
  logic        src_any;                 // Any reset source active.
  logic [15:0] dly_q;                   // Start-up delay counter.
  logic        int_rst;                 // Internal reset level.

  // Delay from fuses: the unit, doubled per start-up step and by clock type.
  function automatic logic [15:0] startup_cycles(input logic [1:0] st, input logic [3:0] cs);
    logic [4:0] sh;
    sh = 5'(st) + 5'(cs[0]);
    return 16'(STARTUP_UNIT << sh);
  endfunction

  // Last tick count of the period; reserved codes fall back to the longest.
  // The longest period needs all 20 bits, so the limit itself would not fit.
  function automatic logic [19:0] wdt_last(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > WDT_SEL_MAX) ? WDT_SEL_MAX : sel;
    return 20'((WDT_BASE_TICKS << s) - 1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset combining and start-up delay.

  // Sources are ORed; the pin is dropped when its disable fuse is programmed.
  assign por_active = ~supply_ok;                                         // [RL4] [RL10]
  assign ext_active = ~ext_reset_pin_n & ~fuses.ext_reset_disable_fuse;   // [RL5] [RL6]
  assign src_any    = por_active | ext_active | brownout_active_q | wdt_pulse_q; // [RL4] [RL25]
  assign int_rst    = src_any | (dly_q != 16'h0000);                      // [RL3]

  // Ports are reset straight from the sources so no clock is needed.
  assign io_port_reset = por_active | ext_active | brownout_active_q | int_rst; // [RL2]
  // The core restarts at its reset vector when this releases.
  assign cpu_reset_n   = ~int_rst;                                        // [RL1]

  // Any active source reloads the delay, so it only runs once all are quiet.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dly_q <= 16'h0000;
    else if (src_any)
      dly_q <= startup_cycles(fuses.startup_time_fuses, fuses.clock_select_fuses); // [RL25]
    else if (dly_q != 16'h0000)
      dly_q <= dly_q - 16'h0001;                                          // [RL3] [RL11]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Brown-out filter.

  assign brownout_enabled = (fuses.brownout_level_fuses != BROWNOUT_OFF);

  // A dip must last the minimum duration; the detector's own hysteresis
  // decides when the supply is back above the upper threshold.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_q            <= 16'h0000;
      brownout_active_q <= 1'b0;
    end
    else if (!brownout_enabled || !brownout_below)
    begin
      filt_q            <= 16'h0000;                                      // [RL9]
      brownout_active_q <= 1'b0;                                          // [RL8]
    end
    else if (filt_q == BROWNOUT_LAST)
      brownout_active_q <= 1'b1;                                          // [RL8]
    else
      filt_q <= filt_q + 16'h0001;                                        // [RL9]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bandgap reference enable.
  assign bandgap_en = brownout_enabled | cmp_bg_q | adc_enable;           // [RL12]

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign wr_fire  = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wbyte    = wdata_q[7:0];
  assign flags_wr = wr_fire & wstrb_q[0] & (awaddr_q == REG_RST_FLAGS);
  assign wdt_wr   = wr_fire & wstrb_q[0] & (awaddr_q == REG_WDT_CTRL);
  assign ref_wr   = wr_fire & wstrb_q[0] & (awaddr_q == REG_REF_CTRL);

  // Ready until a beat is held; address and data are taken in any order.
  assign axi_rsp.awready = ~aw_hold_q & ~bvalid_q;
  assign axi_rsp.wready  = ~w_hold_q & ~bvalid_q;
  assign axi_rsp.arready = ~rvalid_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rresp   = rresp_q;
  assign axi_rsp.rdata   = rdata_q;

  // Write channel capture and response; unmapped offsets answer DECERR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q == REG_RST_FLAGS || awaddr_q == REG_WDT_CTRL ||
                      awaddr_q == REG_REF_CTRL) ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid_q && axi_req.bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read channel; the control register shows the effective mode bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (axi_req.arvalid && axi_rsp.arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      unique case (axi_req.araddr)
        REG_RST_FLAGS: rdata_q[3:0] <= rst_flags_q;
        REG_WDT_CTRL:
        begin
          rdata_q[WC_IRQ_FLAG]         <= irq_flag_q;
          rdata_q[WC_IRQ_EN]           <= irq_en_eff;                     // [RL17]
          rdata_q[WC_SEL3]             <= sel_q[3];
          rdata_q[WC_CHANGE]           <= change_en_q;
          rdata_q[WC_SYSRST]           <= sysrst_eff;                     // [RL22]
          rdata_q[WC_SEL2:WC_SEL0]     <= sel_q[2:0];
        end
        REG_REF_CTRL:  rdata_q[RC_CMP_BANDGAP] <= cmp_bg_q;
        default:       rresp_q <= RESP_DECERR;
      endcase
    end
    else if (rvalid_q && axi_req.rready)
      rvalid_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset cause flags.

  // Flags survive the internal reset so software can read the cause.
  // Power-on clears the others; a new cause wins over a software clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_flags_q <= 4'h0;
    else if (por_active)
      rst_flags_q <= 4'h1;                                                // [RL23]
    else
    begin
      rst_flags_q[FLG_POWERON]  <= rst_flags_q[FLG_POWERON] &
                                   ~(flags_wr & ~wbyte[FLG_POWERON]);     // [RL23]
      rst_flags_q[FLG_EXTERNAL] <= ext_active | (rst_flags_q[FLG_EXTERNAL] &
                                   ~(flags_wr & ~wbyte[FLG_EXTERNAL]));
      rst_flags_q[FLG_BROWNOUT] <= brownout_active_q | (rst_flags_q[FLG_BROWNOUT] &
                                   ~(flags_wr & ~wbyte[FLG_BROWNOUT]));
      rst_flags_q[FLG_WATCHDOG] <= wdt_pulse_q | (rst_flags_q[FLG_WATCHDOG] &
                                   ~(flags_wr & ~wbyte[FLG_WATCHDOG]));
    end
  end

  // Comparator bandgap select; returns to zero on any internal reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_rst)
      cmp_bg_q <= 1'b0;                                                   // [RL1]
    else if (ref_wr)
      cmp_bg_q <= wbyte[RC_CMP_BANDGAP];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog configuration.

  // The fuse overrides both mode bits; the watchdog flag holds reset enable.
  assign sysrst_eff = sysrst_q | rst_flags_q[FLG_WATCHDOG] | fuses.always_on_fuse; // [RL17] [RL22]
  assign irq_en_eff = irq_en_q & ~fuses.always_on_fuse;                   // [RL17]

  // Change sequence: a write with change and reset bits opens a window of
  // four cycles; one write with change clear then sets reset enable and
  // selection freely. Outside a window reset enable can only be set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_rst)
    begin
      sysrst_q     <= 1'b0;
      sel_q        <= 4'h0;
      change_en_q  <= 1'b0;
      change_cnt_q <= 3'h0;
    end
    else if (wdt_wr && wbyte[WC_CHANGE] && wbyte[WC_SYSRST])
    begin
      sysrst_q     <= 1'b1;                                               // [RL18]
      change_en_q  <= 1'b1;
      change_cnt_q <= CHANGE_WINDOW;                                      // [RL21]
    end
    else if (wdt_wr && change_en_q && !wbyte[WC_CHANGE])
    begin
      sysrst_q     <= wbyte[WC_SYSRST];                                   // [RL19]
      sel_q        <= {wbyte[WC_SEL3], wbyte[WC_SEL2:WC_SEL0]};           // [RL19] [RL20]
      change_en_q  <= 1'b0;
      change_cnt_q <= 3'h0;
    end
    else
    begin
      if (wdt_wr && wbyte[WC_SYSRST])
        sysrst_q <= 1'b1;
      if (change_cnt_q == 3'h1)
        change_en_q <= 1'b0;                                              // [RL21]
      if (change_cnt_q != 3'h0)
        change_cnt_q <= change_cnt_q - 3'h1;
    end
  end

  // Interrupt enable: written directly; the vector clears it in combined mode.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_rst)
      irq_en_q <= 1'b0;
    else if (wdt_wr)
      irq_en_q <= wbyte[WC_IRQ_EN];
    else if (wdt_vector_taken && sysrst_eff)
      irq_en_q <= 1'b0;                                                   // [RL24]
  end

  // Interrupt flag: expiry sets, writing one or the vector clears; set wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_rst)
      irq_flag_q <= 1'b0;
    else if (expire && irq_en_eff && !(sysrst_eff && irq_flag_q))
      irq_flag_q <= 1'b1;                                                 // [RL15] [RL16]
    else if ((wdt_wr && wbyte[WC_IRQ_FLAG]) || wdt_vector_taken)
      irq_flag_q <= 1'b0;                                                 // [RL24]
  end

  // Level request; it also serves as the wake-up from sleep.
  assign wdt_irq = irq_flag_q & irq_en_eff;                               // [RL15]

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog timer.

  assign wdt_run = sysrst_eff | irq_en_eff;
  assign tick    = (div_q == 32'(OSC_DIV - 1));
  // Expiry uses >= so shortening the period cannot skip past the limit.
  assign expire  = wdt_run & tick & (wdt_cnt_q >= wdt_last(sel_q));       // [RL13]

  // Divider stands in for the dedicated oscillator; restart clears both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_rst || !wdt_run || wdt_restart)
    begin
      div_q     <= 32'h0000_0000;
      wdt_cnt_q <= 20'h00000;                                             // [RL14]
    end
    else if (tick)
    begin
      div_q     <= 32'h0000_0000;
      wdt_cnt_q <= expire ? 20'h00000 : wdt_cnt_q + 20'h00001;            // [RL13]
    end
    else
      div_q <= div_q + 32'h0000_0001;
  end

  // Reset at expiry in reset mode, or in combined mode once the first
  // interrupt is still pending.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_pulse_q <= 1'b0;
    else
      wdt_pulse_q <= expire & sysrst_eff & (~irq_en_eff | irq_flag_q);   // [RL7] [RL11] [RL16]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_window_open;
    $rose(change_en_q) && !wdt_wr;
  endsequence

  sequence s_window_idle;
    (!wdt_wr)[*3];
  endsequence

  chk_pulse_one_cycle: assert property (wdt_pulse_q |=> !wdt_pulse_q ##1 !cpu_reset_n) // [RL11]
    else $error("watchdog reset pulse wrong width or delay missing");
  chk_delay_holds: assert property (!src_any && dly_q != 16'h0000 |-> !cpu_reset_n) // [RL3]
    else $error("internal reset released during start-up delay");
  chk_poweron_now: assert property (por_active |-> !cpu_reset_n && io_port_reset) // [RL10]
    else $error("power-on reset not immediate");
  chk_pin_resets: assert property (supply_ok && !ext_reset_pin_n && !fuses.ext_reset_disable_fuse
                                   |-> io_port_reset ##1 rst_flags_q[FLG_EXTERNAL]) // [RL5]
    else $error("external pin did not reset");
  chk_change_window: assert property (s_window_open ##1 s_window_idle |=> !change_en_q) // [RL21]
    else $error("change enable not cleared after four cycles");
  chk_always_on: assert property (fuses.always_on_fuse && expire |=> wdt_pulse_q && !wdt_irq) // [RL17]
    else $error("always-on watchdog did not reset");
  chk_irq_mode: assert property (expire && irq_en_eff && !sysrst_eff
                                 |=> irq_flag_q && !wdt_pulse_q) // [RL15]
    else $error("interrupt mode expiry wrong");
  chk_combined_second: assert property (expire && irq_en_eff && sysrst_eff && irq_flag_q
                                        |=> wdt_pulse_q) // [RL16]
    else $error("combined mode second expiry did not reset");
  chk_restart_clears: assert property (wdt_restart |=> wdt_cnt_q == 20'h00000) // [RL14]
    else $error("restart did not clear counter");
  chk_brownout_filter: assert property ($rose(brownout_active_q)
                                        |-> $past(filt_q) == BROWNOUT_LAST) // [RL9]
    else $error("brown-out asserted before minimum duration");
  chk_poweron_flags: assert property (por_active |=> rst_flags_q == 4'h1) // [RL23]
    else $error("power-on did not clear other flags");
  chk_delay_reload: assert property (src_any |=> dly_q ==
    startup_cycles($past(fuses.startup_time_fuses), $past(fuses.clock_select_fuses))) // [RL25]
    else $error("delay not reloaded by active source");

endmodule // rwc_ctrl

// *** bench/rwc_cpu_model.sv ***
// Far-side model: drives the external reset pin and the restart pulse.
// Assumes the bench raises press and kick just after rising edges.
`timescale 1ns/1ns
module rwc_cpu_model (
  input  wire logic aclk,            // System clock.
  input  wire logic press,           // Hold the pin low while high.
  input  wire logic kick,            // Request one restart pulse.
  output logic      ext_reset_pin_n, // Reset pin, low active.
  output logic      wdt_restart      // Restart instruction pulse.
);
  // Whole cycles low, so never shorter than a valid reset pulse.
  always_ff @(posedge aclk) ext_reset_pin_n <= !press;
  // One pulse per kick, as a restart instruction would give.
  always_ff @(posedge aclk) wdt_restart <= kick;
endmodule // rwc_cpu_model

// *** bench/tb_rwc_ctrl.sv ***
// Bench for rwc_ctrl: reset sources, flags, bandgap and watchdog.
// Assumes shortened OSC_DIV 2 and STARTUP_UNIT 4; fuses change only in t_fuse.
`timescale 1ns/1ns
module tb_rwc_ctrl;
  import rwc_pkg::*;
  logic aclk = 0, aresetn = 0, supply_ok = 1, adc = 0, press = 0, kick = 0, bo = 0;
  logic pin_n, rst_n, prst, irq, bg, rs;
  rwc_axi_req_t req = '0;
  rwc_axi_rsp_t rsp;
  rwc_fuse_t fz = rwc_fuse_t'(11'h1C0);
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  rwc_cpu_model cpu (.aclk(aclk), .press(press), .kick(kick), .ext_reset_pin_n(pin_n),
    .wdt_restart(rs));
  rwc_ctrl #(.OSC_DIV(2), .STARTUP_UNIT(4)) uut (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .fuses(fz), .supply_ok(supply_ok),
    .ext_reset_pin_n(pin_n), .brownout_below(bo), .adc_enable(adc), .wdt_restart(rs),
    .wdt_vector_taken(1'b0), .cpu_reset_n(rst_n), .io_port_reset(prst), .wdt_irq(irq),
    .bandgap_en(bg));
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) mismatches++;
    if (g !== e) $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Both beats offered together; each is dropped at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw = 1, w = 1;
    @(posedge aclk) req <= '{a, 1'b1, v, 4'hF, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0};
    do
    begin
      @(posedge aclk);
      aw &= !rsp.awready;
      w &= !rsp.wready;
      req.awvalid <= aw;
      req.wvalid <= w;
    end while (aw || w);
    while (rsp.bvalid !== 1'b1) @(posedge aclk);
    r = rsp.bresp;
    req.bready <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk) req <= '{8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b0, a, 1'b1, 1'b1};
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    #1;
  endtask
  // Waits for the stretched reset to let go, then checks it did.
  task automatic rel;
    for (int i = 0; i < 40 && rst_n !== 1'b1; i++) @(posedge aclk);
    #1 chk(rst_n, 1'b1);
  endtask
  task automatic kk;
    @(posedge aclk) kick <= 1'b1;
    @(posedge aclk) kick <= 1'b0;
  endtask
  task automatic t_por;
    @(posedge aclk) supply_ok <= 1'b0;
    #1 chk({rst_n, prst}, 2'b01);
    @(posedge aclk) supply_ok <= 1'b1;
    cyc(2);
    #1 chk(rst_n, 1'b0);
    rel();
    rd(REG_RST_FLAGS);
    chk(d, 32'h1);
    $display("t_por done");
  endtask
  task automatic t_pin;
    @(posedge aclk) press <= 1'b1;
    cyc(3);
    #1 chk(rst_n, 1'b0);
    @(posedge aclk) press <= 1'b0;
    rel();
    rd(REG_RST_FLAGS);
    chk(d, 32'h3);
    wr(REG_RST_FLAGS, 32'h0);
    rd(REG_RST_FLAGS);
    chk(d, 32'h0);
    rd(8'h0C);
    chk(r, RESP_DECERR);
    $display("t_pin done");
  endtask
  task automatic t_ref;
    wr(REG_REF_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    chk(bg, 1'b1);
    wr(REG_REF_CTRL, 32'h0);
    chk(bg, 1'b0);
    @(posedge aclk) adc <= 1'b1;
    #1 chk(bg, 1'b1);
    $display("t_ref done");
  endtask
  // Period is 2048 ticks of 2 cycles; the kick at 3000 must defer it.
  task automatic t_wdi;
    kk();
    wr(REG_WDT_CTRL, 32'h40);
    cyc(3000);
    kk();
    cyc(2000);
    chk(irq, 1'b0);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
    #1 chk(irq, 1'b1);
    wr(REG_WDT_CTRL, 32'hC0);
    chk(irq, 1'b0);
    $display("t_wdi done");
  endtask
  task automatic t_wdr;
    kk();
    wr(REG_WDT_CTRL, 32'h08);
    for (int i = 0; i < 5000 && rst_n !== 1'b0; i++) @(posedge aclk);
    chk(rst_n, 1'b0);
    rel();
    rd(REG_RST_FLAGS);
    chk(d, 32'h8);
    rd(REG_WDT_CTRL);
    chk(d, 32'h8);
    $display("t_wdr done");
  endtask
  // Change window used on its last cycle, then missed by one cycle.
  task automatic t_chg;
    wr(REG_RST_FLAGS, 32'h0);
    wr(REG_WDT_CTRL, 32'h18);
    wr(REG_WDT_CTRL, 32'h21);
    rd(REG_WDT_CTRL);
    chk(d, 32'h21);
    wr(REG_WDT_CTRL, 32'h18);
    cyc(1);
    wr(REG_WDT_CTRL, 32'h01);
    rd(REG_WDT_CTRL);
    chk(d, 32'h29);
    $display("t_chg done");
  endtask
  // Pin ignored under its disable fuse; short supply dips are filtered.
  task automatic t_fuse;
    @(posedge aclk) fz.ext_reset_disable_fuse <= 1'b1;
    press <= 1'b1;
    cyc(3);
    #1 chk({rst_n, prst}, 2'b10);
    @(posedge aclk) press <= 1'b0;
    fz.brownout_level_fuses <= 3'h0;
    cyc(2);
    bo <= 1'b1;
    cyc(BROWNOUT_MIN_CYC - 10);
    #1 chk(rst_n, 1'b1);
    @(posedge aclk) bo <= 1'b0;
    @(posedge aclk) bo <= 1'b1;
    cyc(BROWNOUT_MIN_CYC + 2);
    #1 chk(rst_n, 1'b0);
    @(posedge aclk) bo <= 1'b0;
    rel();
    rd(REG_RST_FLAGS);
    chk(d, 32'h4);
    $display("t_fuse done");
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    cyc(2);
    t_por();
    t_pin();
    t_ref();
    t_wdi();
    t_wdr();
    t_chg();
    t_fuse();
    final_report();
  end
  initial
  begin
    #400000 mismatches++;
    final_report();
  end
endmodule // tb_rwc_ctrl
